//--- logic/ovc_pkg.sv
// ovc_pkg: shared offsets, field positions, reset values and carriers for the otg supply control
package ovc_pkg;

   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int AW = 6;
   localparam int DW = 8;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [AW-1:0] OFS_FUNC  = 6'h04;
   localparam logic [AW-1:0] OFS_IFC   = 6'h07;
   localparam logic [AW-1:0] OFS_OTG   = 6'h0A;
   localparam logic [AW-1:0] OFS_IER   = 6'h0D;
   localparam logic [AW-1:0] OFS_IEF   = 6'h10;
   localparam logic [AW-1:0] OFS_STAT  = 6'h13;
   localparam logic [AW-1:0] OFS_LATCH = 6'h14;
   localparam logic [AW-1:0] OFS_MASK  = 6'h15;
   localparam logic [AW-1:0] OFS_IOPM  = 6'h39;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int BIT_UART     = 0;
   localparam int BIT_CMPL     = 5;
   localparam int BIT_PASS     = 6;
   localparam int BIT_DISCH    = 3;
   localparam int BIT_CHG      = 4;
   localparam int BIT_DRV_INT  = 5;
   localparam int BIT_DRV_EXT  = 6;
   localparam int BIT_USE_EXT  = 7;
   localparam int BIT_SUP      = 1;
   localparam int BIT_SES      = 2;
   localparam int UREG_LSB     = 0;
   localparam int NREG_LSB     = 2;
   localparam int BIT_PUP_POS  = 4;
   localparam int BIT_PUP_NEG  = 5;

   // ************************************************************
   // reset values and event set
   // ************************************************************
   localparam logic [DW-1:0] RST_FUNC = 8'h00;
   localparam logic [DW-1:0] RST_IFC  = 8'h00;
   localparam logic [DW-1:0] RST_OTG  = 8'h00;
   localparam logic [DW-1:0] RST_IE   = 8'h00;
   localparam logic [DW-1:0] RST_MASK = 8'h00;
   localparam logic [DW-1:0] RST_IOPM = 8'h00;
   localparam logic [DW-1:0] EVT_SET  = 8'h06;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic          we;
      logic          re;
   } ovc_bus_t;

   typedef struct packed {
      logic session;
      logic supply;
   } ovc_cmp_t;

endpackage

//--- logic/ovc_sync2.sv
// ovc_sync2: two-stage synchroniser for the analog comparator outputs
`timescale 1ns/1ns
module ovc_sync2
   import ovc_pkg::*;
(
   input  wire logic     i_mclk,
   input  wire logic     i_rst_n,
   input  wire logic     i_ce,
   input  wire ovc_cmp_t i_raw,
   output ovc_cmp_t      o_sync
);

   ovc_cmp_t stage1;

   // first stage feeds only the second; comparators are asynchronous to mclk
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stage1 <= '0;
         o_sync <= '0;
      end else if (i_ce) begin
         stage1 <= i_raw;
         o_sync <= stage1;
      end
   end

endmodule // ovc_sync2

//--- logic/ovc_top.sv
// ovc_top: otg supply-line control, comparator status, interrupts and uart/charger gating
//
// Contract
// - session interrupt enables only gate interrupts; the session state stays readable.
// - with both supply-valid enables clear, status bit 1 reads 0.
// - rxcmd supply-valid comes from the comparator or a fixed level per the indicator decode.
// - the indicator decode is off after reset so rxcmd follows the comparator.
// - otg control bit 3 switches the supply discharge pull-down.
// - otg control bit 4 switches the supply charge pull-up used to request a session.
// - the charge-pump enable is the or of the internal and external drive bits.
// - the charge-pump enable is active high.
// - in uart mode the regulator selection takes the uart regulator level field.
// - in uart mode no line state is driven on the two lowest data lines.
// - charger pull-ups are off while the reset pin is 0, else follow their enable bits.
`timescale 1ns/1ns
module ovc_top
   import ovc_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic          i_rst_n,
   input  wire logic          i_ce,
   input  wire ovc_bus_t      i_bus,
   output logic [DW-1:0]      o_rdata,
   input  wire ovc_cmp_t      i_cmp,
   input  wire logic          i_reset_n_pin,
   input  wire logic [1:0]    i_linestate,
   output logic               o_rxcmd_supply_valid,
   output logic               o_supply_discharge,
   output logic               o_supply_charge,
   output logic               o_charge_pump_enable_out,
   output logic [1:0]         o_regulator_level,
   output logic [1:0]         o_linestate,
   output logic               o_linestate_oe,
   output logic               o_charger_pos_pullup,
   output logic               o_charger_neg_pullup,
   output logic               o_irq
);

   // ************************************************************
   // helpers
   // ************************************************************

   // address match shared by write and latch read-clear decode; the read port decodes with its own case
   function automatic logic fn_hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
      fn_hit = (a == ofs);
   endfunction

   // indicator decode: with the external indicator selected, complement fixes zero, pass-through fixes one, else the comparator
   function automatic logic fn_decode(input logic use_ext, input logic pass,
                                      input logic cmpl, input logic comp);
      if (!use_ext) begin
         fn_decode = comp;
      end else if (cmpl) begin
         fn_decode = 1'b0;
      end else if (pass) begin
         fn_decode = 1'b1;
      end else begin
         fn_decode = comp;
      end
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   ovc_cmp_t      cmp_s;
   ovc_cmp_t      cmp_d;
   logic [DW-1:0] func_reg;
   logic [DW-1:0] ifc_reg;
   logic [DW-1:0] otg_reg;
   logic [DW-1:0] ier_reg;
   logic [DW-1:0] ief_reg;
   logic [DW-1:0] mask_reg;
   logic [DW-1:0] iopm_reg;
   logic [DW-1:0] latch_reg;
   logic [DW-1:0] status_now;
   logic [DW-1:0] cur_vec;
   logic [DW-1:0] prev_vec;
   logic [DW-1:0] evt;
   logic [DW-1:0] next_latch;
   logic          wr;
   logic          rd;
   logic          sup_en;

   assign wr = i_bus.we;
   assign rd = i_bus.re;

   // ************************************************************
   // comparator synchronisation
   // ************************************************************

   // raw comparators are never looked at before this
   ovc_sync2 u_sync (
      .i_mclk (i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce   (i_ce),
      .i_raw  (i_cmp),
      .o_sync (cmp_s)
   );

   // one-cycle history for edge detection
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmp_d <= '0;
      end else if (i_ce) begin
         cmp_d <= cmp_s;
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************

   // software writes; all fields reset to zero, drive bits included
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         func_reg <= RST_FUNC;
         ifc_reg  <= RST_IFC;
         otg_reg  <= RST_OTG;
         ier_reg  <= RST_IE;
         ief_reg  <= RST_IE;
         mask_reg <= RST_MASK;
         iopm_reg <= RST_IOPM;
      end else if (i_ce && wr) begin
         if (fn_hit(i_bus.addr, OFS_FUNC)) func_reg <= i_bus.wdata;
         if (fn_hit(i_bus.addr, OFS_IFC))  ifc_reg  <= i_bus.wdata;
         if (fn_hit(i_bus.addr, OFS_OTG))  otg_reg  <= i_bus.wdata;
         if (fn_hit(i_bus.addr, OFS_IER))  ier_reg  <= i_bus.wdata;
         if (fn_hit(i_bus.addr, OFS_IEF))  ief_reg  <= i_bus.wdata;
         if (fn_hit(i_bus.addr, OFS_MASK)) mask_reg <= i_bus.wdata;
         if (fn_hit(i_bus.addr, OFS_IOPM)) iopm_reg <= i_bus.wdata;
      end
   end

   // ************************************************************
   // status and events
   // ************************************************************

   // supply comparator counts as disabled only with both enables clear
   assign sup_en = ier_reg[BIT_SUP] | ief_reg[BIT_SUP];

   // session state reads regardless of its enables
   always_comb begin
      status_now           = '0;
      status_now[BIT_SES]  = cmp_s.session;
      status_now[BIT_SUP]  = cmp_s.supply & sup_en;
      cur_vec              = '0;
      cur_vec[BIT_SES]     = cmp_s.session;
      cur_vec[BIT_SUP]     = cmp_s.supply;
      prev_vec             = '0;
      prev_vec[BIT_SES]    = cmp_d.session;
      prev_vec[BIT_SUP]    = cmp_d.supply;
   end

   // enables gate edges here; the comparator level itself is gated only in status bit 1
   always_comb begin
      evt = ((cur_vec & ~prev_vec & ier_reg) |
             (~cur_vec & prev_vec & ief_reg)) & EVT_SET;
   end

   // a read clears the latch, but an event in the same cycle wins
   always_comb begin
      next_latch = latch_reg;
      if (rd && fn_hit(i_bus.addr, OFS_LATCH)) begin
         next_latch = '0;
      end
      next_latch = next_latch | evt;
   end

   // sticky event latch
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_reg <= '0;
      end else if (i_ce) begin
         latch_reg <= next_latch;
      end
   end

   // level interrupt, registered so it stays glitch free
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else if (i_ce) begin
         o_irq <= |(next_latch & mask_reg);
      end
   end

   // ************************************************************
   // read port
   // ************************************************************

   // data valid only in the cycle after the strobe; unmapped reads zero
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= '0;
      end else if (i_ce) begin
         if (rd) begin
            case (i_bus.addr)
               OFS_FUNC:  o_rdata <= func_reg;
               OFS_IFC:   o_rdata <= ifc_reg;
               OFS_OTG:   o_rdata <= otg_reg;
               OFS_IER:   o_rdata <= ier_reg;
               OFS_IEF:   o_rdata <= ief_reg;
               OFS_STAT:  o_rdata <= status_now;
               OFS_LATCH: o_rdata <= latch_reg;
               OFS_MASK:  o_rdata <= mask_reg;
               OFS_IOPM:  o_rdata <= iopm_reg;
               default:   o_rdata <= '0;
            endcase
         end else begin
            o_rdata <= '0;
         end
      end
   end

   // ************************************************************
   // supply-line outputs
   // ************************************************************

   // pulsing resistors and charge pump follow otg control one cycle later
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_supply_discharge       <= 1'b0;
         o_supply_charge          <= 1'b0;
         o_charge_pump_enable_out <= 1'b0;
      end else if (i_ce) begin
         o_supply_discharge       <= otg_reg[BIT_DISCH];
         o_supply_charge          <= otg_reg[BIT_CHG];
         o_charge_pump_enable_out <= otg_reg[BIT_DRV_INT] |
                                     otg_reg[BIT_DRV_EXT];
      end
   end

   // rxcmd supply-valid source; a peripheral link should watch session instead
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rxcmd_supply_valid <= 1'b0;
      end else if (i_ce) begin
         o_rxcmd_supply_valid <= fn_decode(otg_reg[BIT_USE_EXT], ifc_reg[BIT_PASS],
                                           ifc_reg[BIT_CMPL], cmp_s.supply);
      end
   end

   // ************************************************************
   // uart mode and charger detect
   // ************************************************************

   // regulator level swaps automatically on uart entry
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_regulator_level <= '0;
      end else if (i_ce) begin
         if (func_reg[BIT_UART]) begin
            o_regulator_level <= iopm_reg[UREG_LSB +: 2];
         end else begin
            o_regulator_level <= iopm_reg[NREG_LSB +: 2];
         end
      end
   end

   // line state is withheld from the low data lines in uart mode
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_linestate    <= '0;
         o_linestate_oe <= 1'b0;
      end else if (i_ce) begin
         o_linestate_oe <= !func_reg[BIT_UART];
         o_linestate    <= func_reg[BIT_UART] ? 2'h0 : i_linestate;
      end
   end

   // weak pull-ups forced off while the reset pin is low
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_charger_pos_pullup <= 1'b0;
         o_charger_neg_pullup <= 1'b0;
      end else if (i_ce) begin
         o_charger_pos_pullup <= i_reset_n_pin & iopm_reg[BIT_PUP_POS];
         o_charger_neg_pullup <= i_reset_n_pin & iopm_reg[BIT_PUP_NEG];
      end
   end

   // ************************************************************
   // checks
   // ************************************************************

   property p_ses_readable;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && rd && fn_hit(i_bus.addr, OFS_STAT))
         |=> (o_rdata[BIT_SES] == $past(cmp_s.session));
   endproperty
   a_ses_readable: assert property (p_ses_readable)
      else $error("session state not readable in status");

   property p_sup_disabled;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && rd && fn_hit(i_bus.addr, OFS_STAT) && !sup_en)
         |=> (o_rdata[BIT_SUP] == 1'b0);
   endproperty
   a_sup_disabled: assert property (p_sup_disabled)
      else $error("disabled supply status not zero");

   property p_rx_fixed0;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && otg_reg[BIT_USE_EXT] && ifc_reg[BIT_CMPL])
         |=> (o_rxcmd_supply_valid == 1'b0);
   endproperty
   a_rx_fixed0: assert property (p_rx_fixed0)
      else $error("complemented indicator not fixed 0");

   property p_rx_follow;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && !otg_reg[BIT_USE_EXT])
         |=> (o_rxcmd_supply_valid == $past(cmp_s.supply));
   endproperty
   a_rx_follow: assert property (p_rx_follow)
      else $error("rxcmd not following comparator");

   property p_disch;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && wr && fn_hit(i_bus.addr, OFS_OTG)) ##1 i_ce
         |=> (o_supply_discharge == $past(i_bus.wdata[BIT_DISCH], 2));
   endproperty
   a_disch: assert property (p_disch)
      else $error("discharge pull-down mismatch");

   property p_chg;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && wr && fn_hit(i_bus.addr, OFS_OTG)) ##1 i_ce
         |=> (o_supply_charge == $past(i_bus.wdata[BIT_CHG], 2));
   endproperty
   a_chg: assert property (p_chg)
      else $error("charge pull-up mismatch");

   property p_charge_pump_enable_out;
      @(posedge i_mclk) disable iff (!i_rst_n)
      i_ce |=> (o_charge_pump_enable_out ==
                ($past(otg_reg[BIT_DRV_INT]) | $past(otg_reg[BIT_DRV_EXT])));
   endproperty
   a_charge_pump_enable_out: assert property (p_charge_pump_enable_out)
      else $error("charge pump enable not or of drive bits");

   property p_uart_reg;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && func_reg[BIT_UART])
         |=> (o_regulator_level == $past(iopm_reg[UREG_LSB +: 2]));
   endproperty
   a_uart_reg: assert property (p_uart_reg)
      else $error("uart regulator level not selected");

   property p_uart_ls;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && func_reg[BIT_UART]) |=> (!o_linestate_oe && o_linestate == 2'h0);
   endproperty
   a_uart_ls: assert property (p_uart_ls)
      else $error("line state driven in uart mode");

   property p_pullup;
      @(posedge i_mclk) disable iff (!i_rst_n)
      (i_ce && !i_reset_n_pin) |=> (!o_charger_pos_pullup && !o_charger_neg_pullup);
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("charger pull-up on during reset pin low");

endmodule // ovc_top

//--- dv/ovc_link_model.sv
// ovc_link_model: link-side register master with session-valid polling
`timescale 1ns/1ns
module ovc_link_model
   import ovc_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic [DW-1:0] i_rdata,
   output ovc_bus_t           o_bus
);
   initial o_bus = '0;

   // ************************************************************
   // bus cycles
   // ************************************************************
   // one strobe cycle; idle lines carry the inverse so a stale value is never trusted
   task automatic xfer(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic rd,
                       output logic [DW-1:0] q);
      @(posedge i_mclk);
      o_bus <= '{addr: a, wdata: d, we: !rd, re: rd};
      @(posedge i_mclk);
      o_bus <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
      #1 q = i_rdata;
   endtask

   // a peripheral link starts on session valid, not supply valid; bounded poll
   task automatic wait_session(output logic seen);
      logic [DW-1:0] q;
      seen = 1'b0;
      for (int i = 0; i < 8 && !seen; i++) begin
         xfer(OFS_STAT, 8'h00, 1'b1, q);
         seen = q[BIT_SES];
      end
   endtask
endmodule // ovc_link_model

//--- dv/tb.sv
// tb: self-checking bench for the otg supply control block
`timescale 1ns/1ns
module tb;
   import ovc_pkg::*;
   logic           mclk;
   logic           rst_n;
   logic           ce;
   ovc_bus_t       bus;
   logic [DW-1:0]  rdata;
   ovc_cmp_t       cmp;
   logic           pin;
   logic [1:0]     lin;
   logic           rxv, disch, chg, charge_pump_enable_out, oe, pos, neg, irq;
   logic [1:0]     reg_lvl, lout;
   logic [DW-1:0]  q;
   logic           seen;
   int             errors;
   int             checked;
   int             m_func, m_ifc, m_otg, m_iopm;
   logic [AW-1:0]  offs [10] = '{OFS_FUNC, OFS_IFC, OFS_OTG, OFS_IER, OFS_IEF,
                                 OFS_STAT, OFS_LATCH, OFS_MASK, OFS_IOPM, 6'h3F};

   // clock at 4 ns
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   ovc_top ovc_top_inst (
      .i_mclk(mclk), .i_rst_n(rst_n), .i_ce(ce), .i_bus(bus), .o_rdata(rdata),
      .i_cmp(cmp), .i_reset_n_pin(pin), .i_linestate(lin),
      .o_rxcmd_supply_valid(rxv), .o_supply_discharge(disch), .o_supply_charge(chg),
      .o_charge_pump_enable_out(charge_pump_enable_out), .o_regulator_level(reg_lvl),
      .o_linestate(lout), .o_linestate_oe(oe), .o_charger_pos_pullup(pos),
      .o_charger_neg_pullup(neg), .o_irq(irq));

   ovc_link_model ovc_link_model_inst (.i_mclk(mclk), .i_rdata(rdata), .o_bus(bus));

   // ************************************************************
   // compare and bus helpers
   // ************************************************************
   task automatic chk_reg(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_pin(input string n, input logic [1:0] e, input logic [1:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask

   // the model keeps only the registers that steer pins
   task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      ovc_link_model_inst.xfer(a, d, 1'b0, q);
      case (a)
         OFS_FUNC: m_func = d;
         OFS_IFC:  m_ifc = d;
         OFS_OTG:  m_otg = d;
         OFS_IOPM: m_iopm = d;
         default: ;
      endcase
   endtask

   task automatic rreg(input logic [AW-1:0] a, input logic [DW-1:0] e);
      ovc_link_model_inst.xfer(a, 8'h00, 1'b1, q);
      chk_reg("rdata", e, q);
   endtask

   // enough edges for the two sync flops plus the output register
   task automatic settle();
      repeat (4) @(posedge mclk);
      #1;
   endtask

   function automatic logic exp_rx();
      if (!m_otg[BIT_USE_EXT]) return cmp.supply;
      if (m_ifc[BIT_CMPL]) return 1'b0;
      if (m_ifc[BIT_PASS]) return 1'b1;
      return cmp.supply;
   endfunction

   task automatic check_outs();
      logic u;
      u = m_func[BIT_UART];
      chk_pin("discharge", 2'(m_otg[BIT_DISCH]), 2'(disch));
      chk_pin("charge", 2'(m_otg[BIT_CHG]), 2'(chg));
      chk_pin("pump", 2'(m_otg[BIT_DRV_INT] | m_otg[BIT_DRV_EXT]), 2'(charge_pump_enable_out));
      chk_pin("rxcmd", 2'(exp_rx()), 2'(rxv));
      chk_pin("regulator", u ? 2'(m_iopm >> UREG_LSB) : 2'(m_iopm >> NREG_LSB), reg_lvl);
      if (u) begin
         chk_pin("ls_oe", 2'b00, 2'(oe));
         chk_pin("ls", 2'b00, lout);
      end else begin
         chk_pin("ls_oe", 2'b01, 2'(oe));
         chk_pin("ls", lin, lout);
      end
      chk_pin("pullup_pos", 2'(pin & m_iopm[BIT_PUP_POS]), 2'(pos));
      chk_pin("pullup_neg", 2'(pin & m_iopm[BIT_PUP_NEG]), 2'(neg));
   endtask

   task automatic conclude();
      $display("COUNTS checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rst_n = 1'b0;
      ce = 1'b1;
      cmp = '0;
      pin = 1'b0;
      lin = 2'b00;
      errors = 0;
      checked = 0;
      m_func = 0;
      m_ifc = 0;
      m_otg = 0;
      m_iopm = 0;
      void'($urandom(32'hAD7A));
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      // reset values of every register and an unmapped place
      settle();
      check_outs();
      for (int i = 0; i < 10; i++) rreg(offs[i], 8'h00);
      $display("TEST reset done");
      // supply pulsing and pump drive, every drive pairing
      for (int i = 0; i < 8; i++) begin
         wreg(OFS_OTG, {1'b0, 2'(i), 5'($urandom)});
         settle();
         check_outs();
      end
      $display("TEST otg done");
      // indicator decode over all selects and comparator levels
      for (int i = 0; i < 16; i++) begin
         wreg(OFS_IFC, {1'b0, i[1], i[2], 5'h00});
         wreg(OFS_OTG, {i[0], 7'h00});
         @(posedge mclk);
         cmp.supply <= i[3];
         settle();
         check_outs();
      end
      $display("TEST decode done");
      // status readout with enables cleared, read-only status
      @(posedge mclk);
      cmp <= '{session: 1'b1, supply: 1'b1};
      settle();
      rreg(OFS_STAT, 8'h04);
      wreg(OFS_IEF, 8'h02);
      rreg(OFS_STAT, 8'h06);
      wreg(OFS_STAT, 8'hFF);
      rreg(OFS_STAT, 8'h06);
      rreg(OFS_LATCH, 8'h00);
      $display("TEST status done");
      // interrupt raise, clear by read, mask held back then released
      wreg(OFS_MASK, 8'h04);
      wreg(OFS_IER, 8'h04);
      @(posedge mclk);
      cmp.session <= 1'b0;
      settle();
      chk_pin("irq", 2'b00, 2'(irq));
      @(posedge mclk);
      cmp.session <= 1'b1;
      ovc_link_model_inst.wait_session(seen);
      chk_pin("session", 2'b01, 2'(seen));
      settle();
      chk_pin("irq", 2'b01, 2'(irq));
      rreg(OFS_LATCH, 8'h04);
      settle();
      chk_pin("irq", 2'b00, 2'(irq));
      rreg(OFS_LATCH, 8'h00);
      wreg(OFS_MASK, 8'h00);
      @(posedge mclk);
      cmp.supply <= 1'b0;
      settle();
      chk_pin("irq", 2'b00, 2'(irq));
      wreg(OFS_MASK, 8'h02);
      settle();
      chk_pin("irq", 2'b01, 2'(irq));
      rreg(OFS_LATCH, 8'h02);
      settle();
      chk_pin("irq", 2'b00, 2'(irq));
      // session falling edge reaches the latch only through the falling enable
      wreg(OFS_IEF, 8'h06);
      wreg(OFS_MASK, 8'h04);
      @(posedge mclk);
      cmp.session <= 1'b0;
      settle();
      chk_pin("irq", 2'b01, 2'(irq));
      rreg(OFS_LATCH, 8'h04);
      $display("TEST irq done");
      // uart regulator switch, line state gating and charger pull-ups
      for (int i = 0; i < 8; i++) begin
         wreg(OFS_IOPM, 8'($urandom) & 8'h3F);
         wreg(OFS_FUNC, 8'(i & 1));
         @(posedge mclk);
         pin <= i[1];
         lin <= 2'($urandom);
         settle();
         check_outs();
      end
      $display("TEST uart done");
      // clock enable low freezes the read port, so a strobe then is not taken
      @(posedge mclk);
      ce <= 1'b0;
      rreg(OFS_IEF, 8'h00);
      @(posedge mclk);
      ce <= 1'b1;
      rreg(OFS_IEF, 8'h06);
      $display("TEST freeze done");
      conclude();
   end

   // watchdog well beyond the few hundred cycles the tests need
   initial begin
      #80000;
      errors++;
      conclude();
   end
endmodule // tb
